// *** include/pdc_pkg.sv ***
package pdc_pkg;
  // Register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] OFF_COUNT = 4'h0;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Counter and prescaler
  localparam int CNT_W = 8;
  localparam int PRE_W = 7;
  localparam int TAP_W = 3;
  localparam logic [7:0] COUNT_RESET = 8'hF0;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_WRAP = 8'hFF;
  // Control register fields
  localparam int BIT_FLAG = 7;
  localparam int BIT_MASK = 6;
  localparam int BIT_SRC = 5;
  localparam int BIT_PIN = 4;
  localparam int BIT_CLR = 3;
  localparam int BIT_TAP = 0;
  localparam logic RESET_FLAG = 1'b0;
  localparam logic RESET_MASK = 1'b1;
  localparam logic [1:0] RESET_SRC = 2'h0;
  localparam logic [2:0] RESET_TAP = 3'h0;
  // Source modes, {source_select_bit, pin_enable_bit}
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_GATED = 2'h1;
  localparam logic [1:0] SRC_OFF = 2'h2;
  localparam logic [1:0] SRC_PIN = 2'h3;
  // Interrupt vectors
  localparam logic [15:0] VEC_RUN = 16'h1FF8;
  localparam logic [15:0] VEC_WAIT = 16'h1FF6;
  // Instruction cycle clock divider
  localparam int INSTR_DIV = 4;
endpackage

// *** hw/pdc_prescaler.sv ***
`timescale 1ns/100ps
module pdc_prescaler #(
  parameter int PRE_W = pdc_pkg::PRE_W,
  parameter int TAP_W = pdc_pkg::TAP_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic adv_i,
  input wire logic clear_i,
  input wire logic [TAP_W-1:0] tap_i,
  output logic tick_o,
  output logic [PRE_W-1:0] value_o
);
  logic [PRE_W:0] carry;

  // Tap n falls when the low n bits are all ones
  assign carry[0] = 1'b1;
  for (genvar i = 0; i < PRE_W; i++)
  begin : g_carry
    assign carry[i+1] = carry[i] & value_o[i];
  end

  assign tick_o = adv_i & ~clear_i & carry[tap_i];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      value_o <= '0;
    else if (clear_i)
      value_o <= '0;
    else if (adv_i)
      value_o <= value_o + PRE_W'(1);
  end
endmodule // pdc_prescaler

// *** hw/pdc_timer.sv ***
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pdc_timer #(
  parameter int INSTR_DIV = pdc_pkg::INSTR_DIV,
  parameter int ADDR_W = pdc_pkg::ADDR_W
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic EXT_RESET_I,
  input wire logic STOP_I,
  input wire logic WAIT_I,
  input wire logic CPU_IMASK_I,
  input wire logic TIMER_PIN_I,
  output logic TIMER_IRQ_O,
  output logic [15:0] VECTOR_O,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic [2:0] S_AXI_AWPROT_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic [2:0] S_AXI_ARPROT_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O
);
  localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic aw_hit_count;
  logic aw_hit_ctrl;
  logic wr_count;
  logic wr_ctrl;
  logic rd_ctrl;
  logic [DIV_W-1:0] instr_cnt;
  logic instr_tick;
  logic pin_q;
  logic [1:0] src_mode;
  logic src_tick;
  logic adv;
  logic pre_clear;
  logic cnt_tick;
  logic [pdc_pkg::PRE_W-1:0] pre_value;
  logic [7:0] count;
  logic flag;
  logic mask;
  logic src_sel;
  logic pin_en;
  logic [2:0] tap;
  logic zero_evt;
  logic [7:0] ctrl_read;
  logic [31:0] next_rdata;
  logic next_rd_ok;

  // AXI4-Lite handshakes
  assign aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  assign w_take = S_AXI_WVALID_I & S_AXI_WREADY_O;
  assign ar_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  assign do_write = aw_held & w_held & ~S_AXI_BVALID_O;
  assign aw_hit_count = aw_addr[ADDR_W-1:2] == pdc_pkg::OFF_COUNT[3:2];
  assign aw_hit_ctrl = aw_addr[ADDR_W-1:2] == pdc_pkg::OFF_CTRL[3:2];
  assign wr_count = do_write & aw_hit_count & w_lane0;
  assign wr_ctrl = do_write & aw_hit_ctrl & w_lane0;

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      S_AXI_AWREADY_O <= 1'b1;
    end
    else if (aw_take)
    begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR_I;
      S_AXI_AWREADY_O <= 1'b0;
    end
    else if (do_write)
      aw_held <= 1'b0;
    else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
      S_AXI_AWREADY_O <= 1'b1;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      S_AXI_WREADY_O <= 1'b1;
    end
    else if (w_take)
    begin
      w_held <= 1'b1;
      w_byte <= S_AXI_WDATA_I[7:0];
      w_lane0 <= S_AXI_WSTRB_I[0];
      S_AXI_WREADY_O <= 1'b0;
    end
    else if (do_write)
      w_held <= 1'b0;
    else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
      S_AXI_WREADY_O <= 1'b1;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= pdc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= (aw_hit_count || aw_hit_ctrl) ?
        pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
    end
    else if (S_AXI_BREADY_I)
      S_AXI_BVALID_O <= 1'b0;
  end

  assign ctrl_read = {flag, mask, src_sel, pin_en, 1'b0, tap};

  always_comb
  begin
    next_rd_ok = 1'b1;
    next_rdata = 32'h0000_0000;
    if (S_AXI_ARADDR_I[ADDR_W-1:2] == pdc_pkg::OFF_COUNT[3:2])
      next_rdata[7:0] = count;
    else if (S_AXI_ARADDR_I[ADDR_W-1:2] == pdc_pkg::OFF_CTRL[3:2])
      next_rdata[7:0] = ctrl_read;
    else
      next_rd_ok = 1'b0;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= pdc_pkg::RESP_OKAY;
      rd_ctrl <= 1'b0;
    end
    else if (ar_take)
    begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= next_rdata;
      S_AXI_RRESP_O <= next_rd_ok ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
      rd_ctrl <= S_AXI_ARADDR_I[ADDR_W-1:2] == pdc_pkg::OFF_CTRL[3:2];
    end
    else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
    begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // instruction clock never gated by wait
  assign instr_tick = instr_cnt == DIV_W'(INSTR_DIV - 1);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      instr_cnt <= '0;
    else if (instr_tick)
      instr_cnt <= '0;
    else
      instr_cnt <= instr_cnt + DIV_W'(1);
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      pin_q <= 1'b0;
    else
      pin_q <= TIMER_PIN_I;
  end

  assign src_mode = {src_sel, pin_en};

  always_comb
  begin
    unique case (src_mode)
      pdc_pkg::SRC_INTERNAL: src_tick = instr_tick;
      pdc_pkg::SRC_GATED: src_tick = instr_tick & TIMER_PIN_I;
      pdc_pkg::SRC_OFF: src_tick = 1'b0;
      pdc_pkg::SRC_PIN: src_tick = pin_q & ~TIMER_PIN_I;
    endcase
  end

  assign adv = src_tick & ~STOP_I;
  assign pre_clear = STOP_I | (wr_ctrl & w_byte[pdc_pkg::BIT_CLR]);

  pdc_prescaler #(
    .PRE_W(pdc_pkg::PRE_W),
    .TAP_W(pdc_pkg::TAP_W)
  ) u_prescaler (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESET_N_I),
    .adv_i(adv),
    .clear_i(pre_clear),
    .tap_i(tap),
    .tick_o(cnt_tick),
    .value_o(pre_value)
  );

  assign zero_evt = cnt_tick & ~wr_count & (count == pdc_pkg::COUNT_ONE);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      count <= pdc_pkg::COUNT_RESET;
    else if (STOP_I)
      count <= pdc_pkg::COUNT_RESET;
    else if (wr_count)
      count <= w_byte;
    else if (cnt_tick)
      count <= count - pdc_pkg::COUNT_ONE;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      flag <= pdc_pkg::RESET_FLAG;
    else if (EXT_RESET_I || STOP_I)
      flag <= pdc_pkg::RESET_FLAG;
    else if (zero_evt)
      flag <= 1'b1;
    else if (wr_ctrl)
      flag <= w_byte[pdc_pkg::BIT_FLAG];
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      mask <= pdc_pkg::RESET_MASK;
    else if (EXT_RESET_I || STOP_I)
      mask <= pdc_pkg::RESET_MASK;
    else if (wr_ctrl)
      mask <= w_byte[pdc_pkg::BIT_MASK];
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      {src_sel, pin_en} <= pdc_pkg::RESET_SRC;
      tap <= pdc_pkg::RESET_TAP;
    end
    else if (wr_ctrl)
    begin
      src_sel <= w_byte[pdc_pkg::BIT_SRC];
      pin_en <= w_byte[pdc_pkg::BIT_PIN];
      tap <= w_byte[pdc_pkg::BIT_TAP +: pdc_pkg::TAP_W];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      TIMER_IRQ_O <= 1'b0;
      VECTOR_O <= pdc_pkg::VEC_RUN;
    end
    else
    begin
      TIMER_IRQ_O <= flag & ~mask & ~CPU_IMASK_I;
      VECTOR_O <= WAIT_I ? pdc_pkg::VEC_WAIT : pdc_pkg::VEC_RUN;
    end
  end

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);

  property p_zero_sets;
    zero_evt && !EXT_RESET_I |=> flag ##1
      (TIMER_IRQ_O == (!$past(mask) && !$past(CPU_IMASK_I)));
  endproperty
  a_zero_sets: assert property (p_zero_sets)
    else $error("zero event did not raise flag");

  property p_irq_gate;
    TIMER_IRQ_O |-> $past(flag) && !$past(mask) && !$past(CPU_IMASK_I);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while masked");

  property p_vector;
    WAIT_I |=> VECTOR_O == pdc_pkg::VEC_WAIT;
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong vector in wait");

  property p_wrap;
    cnt_tick && !wr_count && !STOP_I && count == pdc_pkg::COUNT_ZERO
      |=> count == pdc_pkg::COUNT_WRAP;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter stopped at zero");

  property p_count_hold;
    !cnt_tick && !wr_count && !STOP_I |=> $stable(count);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("counter moved without tick");

  property p_flag_sticky;
    flag && !wr_ctrl && !EXT_RESET_I && !STOP_I |=> flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped on its own");

  property p_masked_flag;
    zero_evt && mask && !EXT_RESET_I |=> flag && !TIMER_IRQ_O;
  endproperty
  a_masked_flag: assert property (p_masked_flag)
    else $error("masked flag misbehaved");

  property p_pre_clear;
    wr_ctrl && w_byte[pdc_pkg::BIT_CLR] |=> pre_value == '0;
  endproperty
  a_pre_clear: assert property (p_pre_clear)
    else $error("prescaler not cleared");

  property p_clr_reads_zero;
    S_AXI_RVALID_O && rd_ctrl |-> !S_AXI_RDATA_O[pdc_pkg::BIT_CLR];
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero)
    else $error("clear bit read as one");

  property p_off_mode;
    src_mode == pdc_pkg::SRC_OFF |-> !cnt_tick;
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("timer advanced while disabled");

  property p_stop;
    STOP_I |=> count == pdc_pkg::COUNT_RESET && !flag && mask
      && pre_value == '0;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not reset timer state");

  property p_preset;
    wr_count && !STOP_I |=> count == $past(w_byte);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset lost to decrement");

  c_zero: cover property (zero_evt ##[1:3] TIMER_IRQ_O);
  c_pin_mode: cover property (src_mode == pdc_pkg::SRC_PIN && cnt_tick);
  c_set_vs_clear: cover property (zero_evt && wr_ctrl);
  c_wait_vec: cover property (TIMER_IRQ_O && VECTOR_O == pdc_pkg::VEC_WAIT);
endmodule // pdc_timer

// *** bench/pdc_cpu_model.sv ***
`timescale 1ns/100ps
// Processor core as bus master
module pdc_cpu_model (
  input wire logic clk_i,
  output logic awv_o,
  input wire logic awr_i,
  output logic [3:0] awa_o,
  output logic wv_o,
  input wire logic wr_i,
  output logic [31:0] wd_o,
  input wire logic bv_i,
  output logic br_o,
  input wire logic [1:0] bresp_i,
  output logic arv_o,
  input wire logic arr_i,
  output logic [3:0] ara_o,
  input wire logic rv_i,
  output logic rr_o,
  input wire logic [31:0] rd_i,
  input wire logic [1:0] rresp_i
);
  initial
  begin
    awv_o = 1'b0;
    awa_o = 4'h0;
    wv_o = 1'b0;
    wd_o = 32'h0000_0000;
    br_o = 1'b0;
    arv_o = 1'b0;
    ara_o = 4'h0;
    rr_o = 1'b0;
  end
  // Write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_i);
    awv_o <= 1'b1;
    awa_o <= a;
    wv_o <= 1'b1;
    wd_o <= d;
    br_o <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk_i);
      if (!aw && awr_i)
      begin
        aw = 1'b1;
        awv_o <= 1'b0;
        awa_o <= ~a;
      end
      if (!w && wr_i)
      begin
        w = 1'b1;
        wv_o <= 1'b0;
        wd_o <= ~d;
      end
    end
    do @(posedge clk_i); while (!bv_i);
    r = bresp_i;
    br_o <= 1'b0;
  endtask
  // Read, one outstanding
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk_i);
    arv_o <= 1'b1;
    ara_o <= a;
    rr_o <= 1'b1;
    do @(posedge clk_i); while (!arr_i);
    arv_o <= 1'b0;
    ara_o <= ~a;
    do @(posedge clk_i); while (!rv_i);
    d = rd_i;
    r = rresp_i;
    rr_o <= 1'b0;
  endtask
endmodule // pdc_cpu_model

// *** bench/test_prescaled_down_counter.sv ***
`timescale 1ns/100ps
module test_prescaled_down_counter;
  localparam logic [3:0] CNT = pdc_pkg::OFF_COUNT;
  localparam logic [3:0] CTL = pdc_pkg::OFF_CTRL;
  logic clk, rst_n, ext, stop, wt, imask, pin, irq;
  logic [15:0] vec;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [3:0] awa, ara;
  logic [31:0] wd, rdat, d, d1;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] v;
  int miscompares, checked, cycles;
  pdc_timer #(.INSTR_DIV(1)) pdc_timer_inst (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .EXT_RESET_I(ext),
    .STOP_I(stop), .WAIT_I(wt), .CPU_IMASK_I(imask),
    .TIMER_PIN_I(pin), .TIMER_IRQ_O(irq), .VECTOR_O(vec),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWPROT_I(3'h0),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
    .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARPROT_I(3'h0), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp));
  pdc_cpu_model pdc_cpu_model_inst (
    .clk_i(clk), .awv_o(awv), .awr_i(awr), .awa_o(awa), .wv_o(wv),
    .wr_i(wr), .wd_o(wd), .bv_i(bv), .br_o(br), .bresp_i(bresp),
    .arv_o(arv), .arr_i(arr), .ara_o(ara), .rv_i(rv), .rr_o(rr),
    .rd_i(rdat), .rresp_i(rresp));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Control word after an external reset or stop
  function automatic logic [7:0] ctl_after_reset(input logic [7:0] x);
    return {pdc_pkg::RESET_FLAG, pdc_pkg::RESET_MASK, x[5:4], 1'b0,
      x[2:0]};
  endfunction
  task automatic test_done;
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] x);
    pdc_cpu_model_inst.wr(a, {24'h0000_00, x}, resp);
    chk(resp, pdc_pkg::RESP_OKAY);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    pdc_cpu_model_inst.rd(a, d, resp);
    chk(d, {24'h0000_00, e});
    chk(resp, pdc_pkg::RESP_OKAY);
  endtask
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge clk);
      pin <= 1'b0;
      repeat (2) @(posedge clk);
      pin <= 1'b1;
      @(posedge clk);
    end
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done;
    end
  end
  initial
  begin
    v = 8'($urandom(32'h10aab27b));
    {rst_n, ext, wt, imask} = 4'h0;
    {stop, pin} = 2'h3;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(CNT, 8'hF0);
    rchk(CTL, 8'h40);
    @(posedge clk);
    stop <= 1'b0;
    // Presets with source off
    wreg(CTL, 8'h60);
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      wreg(CNT, v);
      rchk(CNT, v);
      rchk(CNT, v);
    end
    // Every tap, counted on pin falls
    for (int t = 0; t < 8; t++)
    begin
      wreg(CNT, 8'h80);
      wreg(CTL, 8'h78 | 8'(t));
      edges((1 << t) - 1);
      rchk(CNT, 8'h80);
      edges(1);
      rchk(CNT, 8'h7F);
    end
    // Gated source
    @(posedge clk);
    pin <= 1'b0;
    wreg(CNT, 8'h80);
    wreg(CTL, 8'h58);
    repeat (20) @(posedge clk);
    rchk(CNT, 8'h80);
    pin <= 1'b1;
    repeat (20) @(posedge clk);
    pin <= 1'b0;
    pdc_cpu_model_inst.rd(CNT, d, resp);
    chk(d, 32'h0000_006C);
    // Internal source while waiting
    wt <= 1'b1;
    wreg(CTL, 8'h40);
    pdc_cpu_model_inst.rd(CNT, d1, resp);
    // Pin toggles ignored in internal mode
    edges(2);
    repeat (2) @(posedge clk);
    pdc_cpu_model_inst.rd(CNT, d, resp);
    chk(32'(d[7:0] < d1[7:0]), 32'h1);
    chk(32'(8'(d1[7:0] - d[7:0])), 32'h0000_000D);
    chk(vec, pdc_pkg::VEC_WAIT);
    wt <= 1'b0;
    // Zero event, count past zero
    wreg(CTL, 8'h60);
    wreg(CNT, 8'h01);
    wreg(CTL, 8'h0F);
    repeat (300) @(posedge clk);
    rchk(CNT, 8'hFF);
    rchk(CTL, 8'h87);
    chk(irq, 1'b1);
    chk(vec, pdc_pkg::VEC_RUN);
    imask <= 1'b1;
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    imask <= 1'b0;
    repeat (40) @(posedge clk);
    rchk(CTL, 8'h87);
    wreg(CTL, 8'h47);
    rchk(CTL, 8'h47);
    wreg(CTL, 8'hC7);
    rchk(CTL, 8'hC7);
    chk(irq, 1'b0);
    // Masked polling
    wreg(CTL, 8'h60);
    wreg(CNT, 8'h01);
    wreg(CTL, 8'h48);
    rchk(CTL, 8'hC0);
    chk(irq, 1'b0);
    wreg(CTL, 8'h80);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    // External reset keeps source and tap
    wreg(CTL, 8'hB5);
    @(posedge clk);
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    rchk(CTL, ctl_after_reset(8'hB5));
    // Unmapped places
    pdc_cpu_model_inst.wr(4'h8, 32'h0000_00FF, resp);
    chk(resp, pdc_pkg::RESP_SLVERR);
    pdc_cpu_model_inst.rd(4'hC, d, resp);
    chk(d, 32'h0000_0000);
    chk(resp, pdc_pkg::RESP_SLVERR);
    // Stop mode
    wreg(CTL, 8'hB5);
    stop <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(CNT, 8'hF0);
    rchk(CTL, ctl_after_reset(8'hB5));
    test_done;
  end
endmodule // test_prescaled_down_counter
